/* File: hw/rsfn_pkg.sv */
// Constants, field layouts and carrier types for the ratio and fractional-N source selector.
package rsfn_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  OFF_RATIO0   = 8'h00;
	localparam logic [7:0]  OFF_RATIO3   = 8'h0c;
	localparam logic [7:0]  OFF_MODE_CFG = 8'h10;
	localparam logic [7:0]  OFF_GLB_CFG  = 8'h14;
	localparam logic [7:0]  OFF_STATUS   = 8'h18;
	localparam logic [7:0]  OFF_EFF      = 8'h1c;
	localparam int unsigned SLOT_LSB     = 2;

	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	localparam int unsigned MODE_STRIDE  = 8;
	localparam int unsigned LOCK_LSB     = 0;
	localparam int unsigned RMOD_LSB     = 2;
	localparam int unsigned SRC_BIT      = 4;
	localparam int unsigned PFC_LSB      = 0;
	localparam int unsigned WIDE_BIT     = 3;
	localparam int unsigned DIV_LSB      = 4;
	localparam logic [31:0] RATIO_RST    = 32'h0010_0000;
	localparam logic [31:0] MODE_CFG_RST = 32'h0302_0100;
	localparam logic [31:0] GLB_CFG_RST  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Pin function codes and ratio arithmetic
	// ----------------------------------------------------------------
	localparam logic [2:0]  PFC_RMOD     = 3'h3;
	localparam logic [2:0]  PFC_AUTO_DIS = 3'h4;
	localparam logic [2:0]  PFC_SRC_SEL  = 3'h6;
	localparam int unsigned RATIO_W      = 32;
	localparam int unsigned HM_SHIFT     = 8;
	localparam int unsigned REFF_W       = RATIO_W + HM_SHIFT;
	localparam int unsigned DIV_W        = 2;
	localparam int unsigned FRACN_W      = REFF_W + 3;
	localparam int unsigned CNT_W        = 24;
	localparam int unsigned LOSS_WAIT    = 1 << 23;
	localparam int unsigned MISS_DEF     = 1 << 20;

	typedef struct packed {
		logic       src;
		logic [1:0] rmod;
		logic [1:0] lock;
	} rsfn_mode_cfg_s;

	typedef struct packed {
		logic [1:0] slot;
		logic       ref_present;
		logic       auto_active;
		logic       wide;
		logic       unlocked;
		logic       dynamic;
	} rsfn_status_s;

	typedef enum logic [1:0] {REF_ABSENT, REF_PRESENT, REF_WAIT} rsfn_ref_e;

endpackage

/* File: hw/rsfn_ratio_select.sv */
// Ratio slot selection, effective ratio and fractional-N source selection with an APB register slave.
`timescale 1ns/1ps
module rsfn_ratio_select #(
	parameter int unsigned MISS_CYCLES = rsfn_pkg::MISS_DEF,
	parameter int unsigned WAIT_CYCLES = rsfn_pkg::LOSS_WAIT
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic [rsfn_pkg::ADDR_W-1:0]   paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [1:0]                    mode_pin,
	input  wire logic                          multi_function_pin,
	input  wire logic                          freq_ref_in,
	input  wire logic [rsfn_pkg::FRACN_W-1:0]  dpll_ratio,
	output logic      [rsfn_pkg::FRACN_W-1:0]  fracn_value,
	output logic      [rsfn_pkg::REFF_W-1:0]   effective_ratio,
	output rsfn_pkg::rsfn_status_s             status
);
	import rsfn_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_f;
	wire  [3:0] pin_raw = {freq_ref_in, multi_function_pin, mode_pin};
	// A pin value is taken once the second and third stages agree; while they differ the last value holds.
	wire  [3:0] next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
			pin_f  <= 4'h0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= next_pin_f;
		end
	end

	wire [1:0] mode_f    = pin_f[1:0];
	wire       mfp_f     = pin_f[2];
	wire       fref_edge = next_pin_f[3] & ~pin_f[3];

	// ----------------------------------------------------------------
	// Configuration registers and APB slave
	// ----------------------------------------------------------------
	logic [RATIO_W-1:0] ratio_mem [4];
	logic [31:0]        mode_cfg_reg;
	logic [31:0]        glb_cfg_reg;
	logic [31:0]        rd_data;
	logic               rd_err;

	wire        wr_acc    = psel & penable & pready & pwrite;
	wire        hit_ratio = (paddr <= OFF_RATIO3) && (paddr[1:0] == 2'h0);
	wire [1:0]  wr_slot   = paddr[SLOT_LSB +: 2];
	wire [31:0] status_w  = {25'h0, status};

	always_comb begin
		rd_data = 32'h0;
		rd_err  = 1'b0;
		if (hit_ratio) begin
			rd_data = ratio_mem[wr_slot];
		end else if (paddr == OFF_MODE_CFG) begin
			rd_data = mode_cfg_reg;
		end else if (paddr == OFF_GLB_CFG) begin
			rd_data = glb_cfg_reg;
		end else if (paddr == OFF_STATUS) begin
			rd_data = status_w;
		end else if (paddr == OFF_EFF) begin
			rd_data = effective_ratio[REFF_W-1 -: 32];
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & rd_err;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_data : 32'h0;
		end
	end

	// The slots hold the stored ratios; the modifier never writes them back.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				ratio_mem[i] <= RATIO_RST;
			end
			mode_cfg_reg <= MODE_CFG_RST;
			glb_cfg_reg  <= GLB_CFG_RST;
		end else if (wr_acc) begin
			if (hit_ratio) begin
				ratio_mem[wr_slot] <= pwdata;
			end else if (paddr == OFF_MODE_CFG) begin
				mode_cfg_reg <= pwdata;
			end else if (paddr == OFF_GLB_CFG) begin
				glb_cfg_reg <= pwdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Frequency reference presence and loss wait
	// ----------------------------------------------------------------
	rsfn_ref_e        ref_state;
	logic [CNT_W-1:0] ref_cnt;
	wire miss_done = ref_cnt == CNT_W'(MISS_CYCLES - 1);
	wire wait_done = ref_cnt == CNT_W'(WAIT_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_state <= REF_ABSENT;
			ref_cnt   <= '0;
		end else if (fref_edge) begin
			ref_state <= REF_PRESENT;
			ref_cnt   <= '0;
		end else begin
			case (ref_state)
				REF_PRESENT: begin
					ref_cnt <= miss_done ? '0 : ref_cnt + 1'b1;
					if (miss_done) begin
						ref_state <= REF_WAIT;
					end
				end
				REF_WAIT: begin
					ref_cnt <= wait_done ? '0 : ref_cnt + 1'b1;
					if (wait_done) begin
						ref_state <= REF_ABSENT;
					end
				end
				default: begin
					ref_cnt <= '0;
				end
			endcase
		end
	end

	wire ref_held = ref_state != REF_ABSENT;

	// ----------------------------------------------------------------
	// Slot and source selection
	// ----------------------------------------------------------------
	rsfn_mode_cfg_s mcfg;
	assign mcfg.lock = mode_cfg_reg[mode_f * MODE_STRIDE + LOCK_LSB +: 2];
	assign mcfg.rmod = mode_cfg_reg[mode_f * MODE_STRIDE + RMOD_LSB +: 2];
	assign mcfg.src  = mode_cfg_reg[mode_f * MODE_STRIDE + SRC_BIT];

	wire [2:0]       pfc         = glb_cfg_reg[PFC_LSB +: 3];
	wire [DIV_W-1:0] ref_div     = glb_cfg_reg[DIV_LSB +: DIV_W];
	wire             auto_en     = mcfg.lock != mode_f;
	wire             auto_dis    = (pfc == PFC_AUTO_DIS) & mfp_f;
	wire             auto_active = auto_en & ~auto_dis;
	wire             man_src     = (pfc == PFC_SRC_SEL) ? mfp_f : mcfg.src;
	wire             dyn_sel     = auto_active ? ref_held : man_src;
	wire [1:0]       slot        = (auto_active & ref_held) ? mcfg.lock : mode_f;
	wire             wide        = glb_cfg_reg[WIDE_BIT] & dyn_sel;
	wire             rmod_en     = (pfc == PFC_RMOD) & mfp_f;

	// ----------------------------------------------------------------
	// Effective ratio, held internally with 20 fraction bits
	// ----------------------------------------------------------------
	wire [RATIO_W-1:0] ud       = ratio_mem[slot];
	wire [REFF_W-1:0]  ud_hm    = {ud, {HM_SHIFT{1'b0}}};
	wire [REFF_W-1:0]  ud_hr    = {{HM_SHIFT{1'b0}}, ud};
	wire [REFF_W-1:0]  ud_fmt   = wide ? ud_hm : ud_hr;
	wire [2:0]         rmod_sh  = {1'b0, mcfg.rmod} + 3'h1;
	wire [REFF_W-1:0]  reff     = rmod_en ? (ud_fmt >> rmod_sh) : ud_fmt;
	wire [FRACN_W-1:0] stat_val = {3'h0, reff} << ref_div;
	wire [FRACN_W-1:0] fracn_w  = dyn_sel ? dpll_ratio : stat_val;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fracn_value     <= '0;
			effective_ratio <= '0;
			status          <= '0;
		end else begin
			fracn_value        <= fracn_w;
			effective_ratio    <= reff;
			status.slot        <= slot;
			status.ref_present <= ref_state == REF_PRESENT;
			status.auto_active <= auto_active;
			status.wide        <= wide;
			status.unlocked    <= ref_state == REF_WAIT;
			status.dynamic     <= dyn_sel;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_manual_slot;
		@(posedge pclk) disable iff (!presetn)
		!auto_active |=> status.slot == $past(mode_f);
	endproperty
	a_manual_slot: assert property (p_manual_slot) else $error("manual slot differs from mode pins");

	property p_auto_slot;
		@(posedge pclk) disable iff (!presetn)
		(auto_active && ref_state == REF_PRESENT) |=> status.slot == $past(mcfg.lock) && status.dynamic;
	endproperty
	a_auto_slot: assert property (p_auto_slot) else $error("auto slot or source wrong");

	property p_wide_only_dyn;
		@(posedge pclk) disable iff (!presetn)
		status.wide |-> status.dynamic;
	endproperty
	a_wide_only_dyn: assert property (p_wide_only_dyn) else $error("wide format without dynamic");

	property p_plain_eff;
		@(posedge pclk) disable iff (!presetn)
		(!rmod_en && !wide) |=> effective_ratio == {8'h00, $past(ud)};
	endproperty
	a_plain_eff: assert property (p_plain_eff) else $error("unmodified ratio wrong");

	property p_half;
		@(posedge pclk) disable iff (!presetn)
		(rmod_en && mcfg.rmod == 2'h0 && !wide) |=> effective_ratio == {9'h000, $past(ud[31:1])};
	endproperty
	a_half: assert property (p_half) else $error("half modifier wrong");

	property p_pin_src;
		@(posedge pclk) disable iff (!presetn)
		(!auto_active && pfc == PFC_SRC_SEL) |=> status.dynamic == $past(mfp_f);
	endproperty
	a_pin_src: assert property (p_pin_src) else $error("pin source override ignored");

	property p_auto_dis;
		@(posedge pclk) disable iff (!presetn)
		(auto_en && pfc == PFC_AUTO_DIS && mfp_f) |=> !status.auto_active;
	endproperty
	a_auto_dis: assert property (p_auto_dis) else $error("auto not disabled by pin");

	property p_wait_end;
		@(posedge pclk) disable iff (!presetn)
		(ref_state == REF_WAIT && wait_done && !fref_edge) |=> ref_state == REF_ABSENT ##1 !status.unlocked;
	endproperty
	a_wait_end: assert property (p_wait_end) else $error("loss wait did not end");

	property p_unlocked;
		@(posedge pclk) disable iff (!presetn)
		(ref_state == REF_WAIT) |=> status.unlocked;
	endproperty
	a_unlocked: assert property (p_unlocked) else $error("unlocked not shown during wait");

	property p_edge_present;
		@(posedge pclk) disable iff (!presetn)
		fref_edge |=> ref_state == REF_PRESENT && ref_cnt == '0;
	endproperty
	a_edge_present: assert property (p_edge_present) else $error("edge did not restart loss counter");

	property p_static_val;
		@(posedge pclk) disable iff (!presetn)
		!dyn_sel |=> fracn_value == $past(stat_val) && !status.dynamic;
	endproperty
	a_static_val: assert property (p_static_val) else $error("static value not driven");

	property p_slot_kept;
		@(posedge pclk) disable iff (!presetn)
		!wr_acc |=> ratio_mem[0] == $past(ratio_mem[0]);
	endproperty
	a_slot_kept: assert property (p_slot_kept) else $error("ratio slot changed without write");

	property p_wide_fmt;
		@(posedge pclk) disable iff (!presetn)
		(wide && !rmod_en) |=> effective_ratio == {$past(ud), 8'h00};
	endproperty
	a_wide_fmt: assert property (p_wide_fmt) else $error("wide format ratio wrong");

	property p_wide_en;
		@(posedge pclk) disable iff (!presetn)
		!glb_cfg_reg[WIDE_BIT] |=> !status.wide;
	endproperty
	a_wide_en: assert property (p_wide_en) else $error("wide format without enable");

	property p_auto_absent;
		@(posedge pclk) disable iff (!presetn)
		(auto_active && ref_state == REF_ABSENT) |=> !status.wide && !status.dynamic && status.slot == $past(mode_f);
	endproperty
	a_auto_absent: assert property (p_auto_absent) else $error("absent reference not static");

	property p_no_rmod;
		@(posedge pclk) disable iff (!presetn)
		(pfc != PFC_RMOD && !wide) |=> effective_ratio == {8'h00, $past(ud)};
	endproperty
	a_no_rmod: assert property (p_no_rmod) else $error("modifier applied without pin function");

	property p_quarter;
		@(posedge pclk) disable iff (!presetn)
		(rmod_en && mcfg.rmod == 2'h1 && !wide) |=> effective_ratio == {10'h000, $past(ud[31:2])};
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter modifier wrong");

	property p_eighth;
		@(posedge pclk) disable iff (!presetn)
		(rmod_en && mcfg.rmod == 2'h2 && !wide) |=> effective_ratio == {11'h000, $past(ud[31:3])};
	endproperty
	a_eighth: assert property (p_eighth) else $error("eighth modifier wrong");

	property p_sixteenth;
		@(posedge pclk) disable iff (!presetn)
		(rmod_en && mcfg.rmod == 2'h3 && !wide) |=> effective_ratio == {12'h000, $past(ud[31:4])};
	endproperty
	a_sixteenth: assert property (p_sixteenth) else $error("sixteenth modifier wrong");

	property p_wide_half;
		@(posedge pclk) disable iff (!presetn)
		(rmod_en && mcfg.rmod == 2'h0 && wide) |=> effective_ratio == {1'b0, $past(ud), 7'h00};
	endproperty
	a_wide_half: assert property (p_wide_half) else $error("half modifier on wide format wrong");

	property p_div_one;
		@(posedge pclk) disable iff (!presetn)
		(!dyn_sel && ref_div == 2'h1) |=> fracn_value == {2'h0, effective_ratio, 1'b0};
	endproperty
	a_div_one: assert property (p_div_one) else $error("divider not compensated");

	property p_dyn_val;
		@(posedge pclk) disable iff (!presetn)
		dyn_sel |=> fracn_value == $past(dpll_ratio) && status.dynamic;
	endproperty
	a_dyn_val: assert property (p_dyn_val) else $error("dynamic value not driven");

	property p_manual_src;
		@(posedge pclk) disable iff (!presetn)
		(!auto_active && pfc != PFC_SRC_SEL) |=> status.dynamic == $past(mcfg.src);
	endproperty
	a_manual_src: assert property (p_manual_src) else $error("per-mode source ignored");

	property p_auto_src;
		@(posedge pclk) disable iff (!presetn)
		auto_active |=> status.dynamic == $past(ref_held);
	endproperty
	a_auto_src: assert property (p_auto_src) else $error("auto source not from reference");

	property p_auto_off;
		@(posedge pclk) disable iff (!presetn)
		(mcfg.lock == mode_f) |=> !status.auto_active;
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("auto active with own slot");

	property p_auto_on;
		@(posedge pclk) disable iff (!presetn)
		(mcfg.lock != mode_f && pfc != PFC_AUTO_DIS) |=> status.auto_active;
	endproperty
	a_auto_on: assert property (p_auto_on) else $error("auto not active with other slot");

	property p_auto_pin_low;
		@(posedge pclk) disable iff (!presetn)
		(auto_en && pfc == PFC_AUTO_DIS && !mfp_f) |=> status.auto_active;
	endproperty
	a_auto_pin_low: assert property (p_auto_pin_low) else $error("auto lost with pin low");

	property p_wait_dyn;
		@(posedge pclk) disable iff (!presetn)
		(auto_active && ref_state == REF_WAIT) |=> status.dynamic && status.unlocked;
	endproperty
	a_wait_dyn: assert property (p_wait_dyn) else $error("loss wait switched too early");

	property p_present_lock;
		@(posedge pclk) disable iff (!presetn)
		(ref_state == REF_PRESENT) |=> status.ref_present && !status.unlocked;
	endproperty
	a_present_lock: assert property (p_present_lock) else $error("present reference shown wrong");

endmodule

/* File: tb/rsfn_ref_model.sv */
// Board-side model of the frequency reference clock, which stands still while stopped.
`timescale 1ns/1ps
module rsfn_ref_model #(
	parameter int unsigned HALF = 3
) (
	input  wire logic pclk,
	input  wire logic run,
	output logic      freq_ref_in
);
	int   cnt   = 0;
	logic level = 1'b0;

	assign freq_ref_in = level;

	always @(posedge pclk) begin
		if (!run) begin
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			level <= ~level;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

/* File: tb/rsfn_ratio_select_tb.sv */
// Self-checking testbench for the ratio and fractional-N source selector.
`timescale 1ns/1ps
module rsfn_ratio_select_tb;
	import rsfn_pkg::*;
	localparam logic [FRACN_W-1:0] DPLL = 43'h5a5_a5a5_1234;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [ADDR_W-1:0]     paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic [1:0]            mode_pin;
	logic                  multi_function_pin, freq_ref_in, ref_run;
	logic [FRACN_W-1:0]    dpll_ratio, fracn_value;
	logic [REFF_W-1:0]     effective_ratio, e;
	rsfn_status_s          status;
	int                    error_cnt, n_compared;

	always #20 pclk = ~pclk;

	rsfn_ratio_select #(.MISS_CYCLES(16), .WAIT_CYCLES(32)) i_rsfn_ratio_select (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mode_pin(mode_pin), .multi_function_pin(multi_function_pin),
		.freq_ref_in(freq_ref_in), .dpll_ratio(dpll_ratio), .fracn_value(fracn_value),
		.effective_ratio(effective_ratio), .status(status));
	rsfn_ref_model i_rsfn_ref_model (.pclk(pclk), .run(ref_run), .freq_ref_in(freq_ref_in));

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			$display("CHECK FAILED t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
			error_cnt++;
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic mcfg(input int m, input logic [1:0] lk, input logic [1:0] rs, input logic s);
		logic [31:0] v;
		v = MODE_CFG_RST;
		v[m*8 +: 8] = {3'h0, s, rs, lk};
		apb(1'b1, OFF_MODE_CFG, v);
	endtask

	task automatic glb(input logic [2:0] pf, input logic wd, input logic [1:0] dv);
		apb(1'b1, OFF_GLB_CFG, {26'h0, dv, wd, pf});
	endtask

	task automatic setr(input int m, input logic [31:0] ud);
		apb(1'b1, 8'(m << SLOT_LSB), ud);
	endtask

	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask

	// Expected 20.20 effective ratio from a stored ratio, format and modifier.
	function automatic logic [REFF_W-1:0] xeff(input logic [31:0] ud, input logic wd, input logic on,
		input logic [1:0] sel);
		logic [REFF_W-1:0] v;
		v = wd ? {ud, 8'h00} : {8'h00, ud};
		return on ? v >> (sel + 1) : v;
	endfunction

	task automatic t_reset();
		apb(1'b0, OFF_RATIO3, 32'h0);
		chk(rd, RATIO_RST, "ratio reset");
		apb(1'b0, OFF_MODE_CFG, 32'h0);
		chk(rd, MODE_CFG_RST, "mode cfg reset");
		apb(1'b0, OFF_GLB_CFG, 32'h0);
		chk(rd, GLB_CFG_RST, "global cfg reset");
		apb(1'b0, 8'h20, 32'h0);
		chk({rd, 31'h0, er}, 64'h1, "unmapped read");
		$display("reset test done");
	endtask

	task automatic t_manual();
		for (int m = 0; m < 4; m++) begin
			setr(m, 32'h0812_3450 + 32'(m));
			mode_pin <= 2'(m);
			settle();
			e = xeff(32'h0812_3450 + 32'(m), 1'b0, 1'b0, 2'h0);
			chk(effective_ratio, e, "12.20 ratio");
			chk(status.slot, m, "slot by mode");
			chk(fracn_value, {3'h0, e}, "static source");
			apb(1'b0, OFF_EFF, 32'h0);
			chk(rd, e[39:8], "eff register");
		end
		glb(3'h0, 1'b0, 2'h2);
		settle();
		chk(effective_ratio, e, "eff ignores divider");
		chk(fracn_value, {1'b0, e, 2'h0}, "divider compensation");
		$display("manual test done");
	endtask

	task automatic t_rmod();
		mode_pin <= 2'h1;
		setr(1, 32'h0030_0000);
		glb(PFC_RMOD, 1'b0, 2'h0);
		for (int s = 0; s < 4; s++) begin
			mcfg(1, 2'h1, 2'(s), 1'b0);
			multi_function_pin <= 1'b1;
			settle();
			chk(effective_ratio, xeff(32'h0030_0000, 1'b0, 1'b1, 2'(s)), "modifier on");
			multi_function_pin <= 1'b0;
			settle();
			chk(effective_ratio, xeff(32'h0030_0000, 1'b0, 1'b0, 2'h0), "modifier off");
		end
		apb(1'b0, OFF_RATIO0 + 8'h04, 32'h0);
		chk(rd, 32'h0030_0000, "slot unchanged");
		glb(PFC_SRC_SEL, 1'b0, 2'h0);
		multi_function_pin <= 1'b1;
		settle();
		chk(effective_ratio, xeff(32'h0030_0000, 1'b0, 1'b0, 2'h0), "modifier only by pin");
		$display("modifier test done");
	endtask

	task automatic t_src();
		glb(PFC_SRC_SEL, 1'b1, 2'h0);
		mcfg(1, 2'h1, 2'h0, 1'b0);
		multi_function_pin <= 1'b0;
		settle();
		chk(effective_ratio, {8'h00, 32'h0030_0000}, "wide needs dynamic");
		chk(status.dynamic, 1'b0, "pin low static");
		multi_function_pin <= 1'b1;
		settle();
		chk(fracn_value, DPLL, "pin high dynamic");
		chk(effective_ratio, {32'h0030_0000, 8'h00}, "20.12 ratio");
		glb(3'h0, 1'b0, 2'h0);
		mcfg(1, 2'h1, 2'h0, 1'b1);
		settle();
		chk(fracn_value, DPLL, "per-mode source dynamic");
		$display("source test done");
	endtask

	task automatic t_auto();
		mode_pin <= 2'h0;
		multi_function_pin <= 1'b0;
		setr(0, 32'h0010_8000);
		setr(2, 32'h0400_0000);
		glb(PFC_AUTO_DIS, 1'b1, 2'h0);
		mcfg(0, 2'h2, 2'h0, 1'b1);
		settle();
		chk({status.slot, status.auto_active, status.wide, status.dynamic}, 5'h04, "auto absent");
		chk(effective_ratio, {8'h00, 32'h0010_8000}, "absent uses 12.20");
		ref_run <= 1'b1;
		repeat (30) @(posedge pclk);
		chk({status.slot, status.ref_present, status.wide, status.dynamic}, 5'h17, "auto present");
		chk(fracn_value, DPLL, "present uses dynamic");
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h0000_005d, "status register");
		multi_function_pin <= 1'b1;
		settle();
		chk({status.slot, status.auto_active, status.dynamic}, 4'h1, "pin disables auto");
		multi_function_pin <= 1'b0;
		ref_run <= 1'b0;
		repeat (30) @(posedge pclk);
		chk({status.unlocked, status.dynamic}, 2'h3, "loss waits unlocked");
		repeat (40) @(posedge pclk);
		chk({status.slot, status.dynamic}, 3'h0, "after wait static");
		$display("auto test done");
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{mode_pin, multi_function_pin, ref_run} = '0;
		dpll_ratio = DPLL;
		error_cnt = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_manual();
		t_rmod();
		t_src();
		t_auto();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_of_test();
	end
endmodule
